/* sar_seq_pkg.sv */
// Shared constants and types for the dual conversion sequencer.
// Assumes one system clock; the conversion clock, start and read pins are resynchronised by the user module.
package sar_seq_pkg;

    // ========================================
    // Converter geometry
    // ========================================
    localparam int unsigned RES_W        = 12;  // Result width of each converter.
    localparam int unsigned NUM_CONV     = 2;   // Converters sampled together.
    localparam int unsigned CNT_W        = 4;   // Width of the bit-step counter.
    localparam logic [3:0]  LAST_STEP    = 4'hb; // Step index of the last decision.

    // ========================================
    // Link clock limits and full-cycle budget
    // ========================================
    localparam int unsigned CONV_CLK_MIN_HZ = 1000000;   // Slowest conversion clock.
    localparam int unsigned CONV_CLK_MAX_HZ = 32000000;  // Fastest conversion clock.
    localparam int unsigned CYCLE_BUDGET    = 16;        // Clocks per full cycle.
    localparam int unsigned SAMPLE_MIN      = 2;         // Least sampling clocks.

    // ========================================
    // Multiplexer source codes and select codes
    // ========================================
    localparam logic [1:0] SRC_PAIR0_POS = 2'h0; // Pair 0 positive input.
    localparam logic [1:0] SRC_PAIR0_NEG = 2'h1; // Pair 0 negative input.
    localparam logic [1:0] SRC_PAIR1_POS = 2'h2; // Pair 1 positive input.
    localparam logic [1:0] SRC_PAIR1_NEG = 2'h3; // Pair 1 negative input.

    localparam logic [1:0] SEL_PAIR0     = 2'h0; // Pair 0 differential.
    localparam logic [1:0] SEL_P1NEG     = 2'h1; // Pair 1 negative against common.
    localparam logic [1:0] SEL_P1POS     = 2'h2; // Pair 1 positive against common.
    localparam logic [1:0] SEL_PAIR1     = 2'h3; // Pair 1 differential.

    // ========================================
    // Sequencer states
    // ========================================
    typedef enum logic [1:0] {
        ST_ACQUIRE,    // Switches closed, tracking the inputs.
        ST_HOLD,       // Switches open, waiting for a conversion clock rise.
        ST_CONVERT,    // Successive approximation running.
        ST_PRECHARGE   // Capacitors tied to the reference input.
    } seq_state_t;

endpackage : sar_seq_pkg

/* dual_sar_conversion_sequencer.sv */
// Sequencer for two simultaneous 12-bit successive-approximation converters.
// Assumes the conversion clock, start strobe and read strobe arrive as pins
// from a host, and the comparator decisions come from logic on clk_i.
// Function
// R1: Both converters hold and convert together.
// R2: Differential codes 00, 11 pick pair 0, 1.
// R3: Pseudo codes 00, 01, 10 against pair-0 negative.
// R4: Channel select comes from configuration field.
// R5: Start strobe rise enters hold immediately.
// R6: Conversion begins at next clock rise.
// R7: Host never starts while busy is high.
// R8: Read strobe sampled on falling clock edges.
// R9: Host clock stays between 1 and 32 MHz.
// R10: Conversion takes exactly twelve clock cycles.
// R11: One precharge cycle, then acquisition restarts.
// R12: Host allows sampling time, sixteen-clock budget.
// R13: Clock may stop low; state is kept.
// R14: Clock may stop after 14th falling edge.
// R15: Busy low throughout acquisition.
// R16: Host keeps clock duty 30 to 70 percent.
// R17: Busy high from hold to conversion end.
// R18: Results latched at end of conversion.
`timescale 1ns/1ps

module dual_sar_conversion_sequencer
    import sar_seq_pkg::*;
(
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         conv_clk_i,
    input  wire logic                         conv_start_strobe_i,
    input  wire logic                         read_strobe_i,
    input  wire logic                         chan_sel_hi_i,
    input  wire logic                         chan_sel_lo_i,
    input  wire logic [NUM_CONV-1:0]          cmp_i,
    output logic                              busy_o,
    output logic                              sample_close_o,
    output logic                              precharge_o,
    output logic [1:0]                        pos_src_o,
    output logic [1:0]                        neg_src_o,
    output logic [NUM_CONV-1:0][RES_W-1:0]    trial_o,
    output logic [NUM_CONV-1:0][RES_W-1:0]    result_o,
    output logic                              result_valid_o,
    output logic                              read_pulse_o
);

    // ========================================
    // Pin synchronisers
    // ========================================
    // Stage one of each chain feeds only stage two; in the clock and start
    // chains stage three is the history used for edge detection.
    logic [2:0] clk_sync_reg;   // Conversion clock chain.
    logic [2:0] clk_sync_next;  // Next value of the clock chain.
    logic [2:0] cs_sync_reg;    // Start strobe chain.
    logic [2:0] cs_sync_next;   // Next value of the start chain.
    logic [1:0] rd_sync_reg;    // Read strobe chain.
    logic [1:0] rd_sync_next;   // Next value of the read chain.
    logic       clk_rise;       // Conversion clock rising edge seen.
    logic       clk_fall;       // Conversion clock falling edge seen.
    logic       start_rise;     // Start strobe rising edge seen.

    // Shift each pin one stage deeper.
    always_comb begin
        clk_sync_next = {clk_sync_reg[1:0], conv_clk_i};
        cs_sync_next  = {cs_sync_reg[1:0], conv_start_strobe_i};
        rd_sync_next  = {rd_sync_reg[0], read_strobe_i};
    end

    // Register the synchroniser chains.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_sync_reg <= 3'h0;
            cs_sync_reg  <= 3'h0;
            rd_sync_reg  <= 2'h0;
        end else begin
            clk_sync_reg <= clk_sync_next;
            cs_sync_reg  <= cs_sync_next;
            rd_sync_reg  <= rd_sync_next;
        end
    end

    // Edge detection costs about three clk_i cycles of latency, so the conversion
    // clock must stay well below clk_i for every one of its edges to be seen.
    // Edges come from stages two and three only.
    assign clk_rise   = clk_sync_reg[1] & ~clk_sync_reg[2];
    assign clk_fall   = ~clk_sync_reg[1] & clk_sync_reg[2];
    assign start_rise = cs_sync_reg[1] & ~cs_sync_reg[2];

    // ========================================
    // Sequencer state machine
    // ========================================
    seq_state_t       state_reg;   // Current phase.
    seq_state_t       state_next;  // Next phase.
    logic [CNT_W-1:0] step_reg;    // Bit decision index.
    logic [CNT_W-1:0] step_next;   // Next bit decision index.
    logic             begin_conv;  // Conversion starts this cycle.
    logic             decide;      // One bit decision is taken this cycle.
    logic             last_bit;    // The decision taken is the last one.

    // Walk acquire, hold, convert and precharge. Only the start rise in acquire moves
    // without a conversion clock rise, so a stopped clock freezes hold, convert and precharge.
    always_comb begin
        state_next = state_reg;
        step_next  = step_reg;
        begin_conv = 1'b0;
        decide     = 1'b0;
        last_bit   = 1'b0;
        case (state_reg)
            ST_ACQUIRE: begin
                // A start rise opens the switches at once, clock or not.
                if (start_rise) begin
                    state_next = ST_HOLD; // R5
                end
            end
            ST_HOLD: begin
                // A start tied to the read strobe lands here too, so the
                // following rise begins the conversion.
                if (clk_rise) begin
                    state_next = ST_CONVERT; // R6 R8
                    step_next  = '0;
                    begin_conv = 1'b1;
                end
            end
            ST_CONVERT: begin
                // Start rises are ignored while busy; the host avoids them.
                if (clk_rise) begin
                    decide = 1'b1; // R7
                    if (step_reg == LAST_STEP) begin
                        last_bit   = 1'b1;
                        state_next = ST_PRECHARGE; // R10
                    end else begin
                        step_next = step_reg + 4'h1; // R10
                    end
                end
            end
            ST_PRECHARGE: begin
                // One full clock cycle on the reference, then reconnect.
                if (clk_rise) begin
                    state_next = ST_ACQUIRE; // R11
                end
            end
            default: begin
                state_next = ST_ACQUIRE;
            end
        endcase
    end

    // Register the phase and step. State is held between edges. R13 R14
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_ACQUIRE;
            step_reg  <= '0;
        end else begin
            state_reg <= state_next;
            step_reg  <= step_next;
        end
    end

    // ========================================
    // Switch control and busy flag
    // ========================================
    logic busy_next;     // Busy for the next cycle.
    logic close_next;    // Sampling switches closed next cycle.
    logic prech_next;    // Precharge switch closed next cycle.

    // Decode the outputs from the next phase so they change with it.
    always_comb begin
        busy_next  = (state_next == ST_HOLD) || (state_next == ST_CONVERT); // R17
        close_next = (state_next == ST_ACQUIRE); // R15 R1
        prech_next = (state_next == ST_PRECHARGE); // R11
    end

    // Register the switch controls.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o         <= 1'b0;
            sample_close_o <= 1'b1;
            precharge_o    <= 1'b0;
        end else begin
            busy_o         <= busy_next; // R15
            sample_close_o <= close_next;
            precharge_o    <= prech_next;
        end
    end

    // ========================================
    // Input multiplexer selection
    // ========================================
    logic [1:0] pos_next;  // Positive source for both converters.
    logic [1:0] neg_next;  // Negative source for both converters.
    logic [1:0] sel;       // Channel-select field from configuration.

    // The field already lives on clk_i, so it is read without a synchroniser.
    assign sel = {chan_sel_hi_i, chan_sel_lo_i}; // R4

    // One table serves both uses; both converters share the selection.
    always_comb begin
        case (sel)
            SEL_PAIR0: begin
                pos_next = SRC_PAIR0_POS; // R2 R3
                neg_next = SRC_PAIR0_NEG;
            end
            SEL_P1NEG: begin
                pos_next = SRC_PAIR1_NEG; // R3
                neg_next = SRC_PAIR0_NEG;
            end
            SEL_P1POS: begin
                pos_next = SRC_PAIR1_POS; // R3
                neg_next = SRC_PAIR0_NEG;
            end
            default: begin
                pos_next = SRC_PAIR1_POS; // R2
                neg_next = SRC_PAIR1_NEG;
            end
        endcase
    end

    // Register the selection.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pos_src_o <= SRC_PAIR0_POS;
            neg_src_o <= SRC_PAIR0_NEG;
        end else begin
            pos_src_o <= pos_next;
            neg_src_o <= neg_next;
        end
    end

    // ========================================
    // Successive approximation, one per converter
    // ========================================
    logic [RES_W-1:0] bit_mask; // Bit decided at the current step.

    // The mask walks from the top bit down as the step index climbs; step zero
    // tests the top bit and the last step tests bit zero.
    assign bit_mask = {{(RES_W-1){1'b0}}, 1'b1} << (LAST_STEP - step_reg);

    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++) begin : g_conv
            logic [RES_W-1:0] trial_next;  // Next trial code.
            logic [RES_W-1:0] res_next;    // Next held result.

            // Both converters step on the same edges from the same state.
            always_comb begin
                trial_next = trial_o[g];
                res_next   = result_o[g];
                if (begin_conv) begin
                    trial_next = {1'b1, {(RES_W-1){1'b0}}}; // R1
                end else if (decide) begin
                    // Drop the trial bit when the comparator says too high.
                    trial_next = cmp_i[g] ? trial_o[g] : (trial_o[g] & ~bit_mask);
                    if (!last_bit) begin
                        trial_next = trial_next | (bit_mask >> 1);
                    end else begin
                        res_next = trial_next; // R18
                    end
                end
            end

            // Register trial and held result.
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    trial_o[g]  <= '0;
                    result_o[g] <= '0;
                end else begin
                    trial_o[g]  <= trial_next;
                    result_o[g] <= res_next;
                end
            end
        end
    endgenerate

    // ========================================
    // Result valid flag and read strobe sampling
    // ========================================
    logic valid_next;  // Result readable next cycle.
    logic read_next;   // Read pulse next cycle.

    // Results stay readable until the next start; reads use falling edges.
    // Setting on the last decision wins over a clear; a start cannot be
    // accepted in that cycle because the phase is then not acquire.
    always_comb begin
        valid_next = result_valid_o;
        if (last_bit) begin
            valid_next = 1'b1; // R18
        end else if (start_rise && state_reg == ST_ACQUIRE) begin
            valid_next = 1'b0;
        end
        read_next = clk_fall & rd_sync_reg[1]; // R8
    end

    // Register the flag and the pulse.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_valid_o <= 1'b0;
            read_pulse_o   <= 1'b0;
        end else begin
            result_valid_o <= valid_next;
            read_pulse_o   <= read_next;
        end
    end

endmodule : dual_sar_conversion_sequencer

/* seq_chk.sv */
// Port checker for the dual conversion sequencer.
// Assumes binding to the design top and a conversion clock far slower than clk_i.
`timescale 1ns/1ps

module seq_chk
    import sar_seq_pkg::*;
(
    input wire logic                            clk_i,
    input wire logic                            sys_rst_i,
    input wire logic                            conv_clk_i,
    input wire logic                            conv_start_strobe_i,
    input wire logic                            chan_sel_hi_i,
    input wire logic                            chan_sel_lo_i,
    input wire logic                            busy_o,
    input wire logic                            sample_close_o,
    input wire logic                            precharge_o,
    input wire logic [1:0]                      pos_src_o,
    input wire logic [1:0]                      neg_src_o,
    input wire logic [NUM_CONV-1:0][RES_W-1:0]  result_o,
    input wire logic                            result_valid_o,
    input wire logic                            read_pulse_o
);
    // ========================================
    // Clock rises counted since the last start
    // ========================================
    logic       clk_q_reg, clk_q_next;    // Last pin level of the conversion clock.
    logic       st_q_reg, st_q_next;      // Last pin level of the start strobe.
    logic [4:0] rises_reg, rises_next;    // Rises seen since the start rise.

    // The rise that carries the start is not counted, so the begin rise is the first.
    always_comb begin
        clk_q_next = conv_clk_i;
        st_q_next  = conv_start_strobe_i;
        rises_next = rises_reg;
        if (conv_start_strobe_i && !st_q_reg) begin
            rises_next = 5'h0;
        end else if (conv_clk_i && !clk_q_reg) begin
            rises_next = rises_reg + 5'h1;
        end
    end

    // Registers only.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_q_reg <= 1'b0;
            st_q_reg  <= 1'b0;
            rises_reg <= 5'h0;
        end else begin
            clk_q_reg <= clk_q_next;
            st_q_reg  <= st_q_next;
            rises_reg <= rises_next;
        end
    end

    // ========================================
    // Assertions
    // ========================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_start;
        $rose(conv_start_strobe_i) && sample_close_o;
    endsequence
    sequence s_done;
        $fell(busy_o);
    endsequence

    a_start_hold: assert property (s_start |-> ##[3:6] busy_o)
        else $error("busy did not follow start");
    a_busy_acq: assert property (sample_close_o |-> !busy_o && !precharge_o)
        else $error("busy during acquisition");
    a_hold_open: assert property (busy_o |-> !sample_close_o && !precharge_o)
        else $error("switches closed while busy");
    a_conv_len: assert property (s_done |-> rises_reg == 5'hd)
        else $error("conversion length wrong");
    a_pre_after: assert property (s_done |-> precharge_o)
        else $error("no precharge after conversion");
    a_pre_end: assert property ($fell(precharge_o) |-> sample_close_o)
        else $error("acquisition not resumed after precharge");
    a_res_latch: assert property (s_done |-> ##[0:1] result_valid_o)
        else $error("results not latched");
    a_res_hold: assert property (result_valid_o && $past(result_valid_o) |-> $stable(result_o))
        else $error("held results changed");
    a_mux_diff: assert property ({chan_sel_hi_i, chan_sel_lo_i} == SEL_PAIR1 |=>
        pos_src_o == SRC_PAIR1_POS && neg_src_o == SRC_PAIR1_NEG)
        else $error("differential pair 1 wrong");
    a_mux_pseudo: assert property ({chan_sel_hi_i, chan_sel_lo_i} == SEL_P1NEG |=>
        pos_src_o == SRC_PAIR1_NEG && neg_src_o == SRC_PAIR0_NEG)
        else $error("pseudo code 01 wrong");
    a_read_one: assert property (read_pulse_o |=> !read_pulse_o)
        else $error("read pulse too long");
endmodule : seq_chk

/* host_model.sv */
// Host model: makes the conversion clock and the tied start and read strobe.
// Assumes a request level from the bench; answers promptly or slowly.
`timescale 1ns/1ps

module host_model (
    input  wire logic slow_i,
    input  wire logic req_i,
    output logic      conv_clk_o,
    output logic      start_o,
    output logic      active_o
);
    // One frame: start rides on a clock rise, then sixteen more cycles, clock left low.
    initial begin
        conv_clk_o = 1'b0;
        start_o    = 1'b0;
        active_o   = 1'b0;
        forever begin
            wait (req_i === 1'b1);
            active_o = 1'b1;
            for (int i = 0; i <= 16; i++) begin
                conv_clk_o = 1'b1;
                start_o    = (i == 0);
                #(slow_i ? 500 : 450);
                conv_clk_o = 1'b0;
                #(slow_i ? 500 : 450);
            end
            active_o = 1'b0;
            wait (req_i === 1'b0);
        end
    end
endmodule : host_model

/* testbench.sv */
// Self-checking bench for the dual conversion sequencer.
// Assumes the host model drives the pins and the checker is bound below.
`timescale 1ns/1ps

module testbench
    import sar_seq_pkg::*;
;
    // ========================================
    // Signals and bench model state
    // ========================================
    logic                           clk_i = 1'b0;
    logic                           sys_rst_i = 1'b1;
    logic                           chan_sel_hi_i = 1'b0;
    logic                           chan_sel_lo_i = 1'b0;
    logic [NUM_CONV-1:0]            cmp_i = '0;
    logic                           slow = 1'b0;
    logic                           req = 1'b0;
    wire logic                      conv_clk;
    wire logic                      start;
    wire logic                      host_active;
    logic                           busy_o, sample_close_o, precharge_o;
    logic                           result_valid_o, read_pulse_o;
    logic [1:0]                     pos_src_o, neg_src_o;
    logic [NUM_CONV-1:0][RES_W-1:0] result_o;
    logic [NUM_CONV-1:0][RES_W-1:0] trial_o;          // Running trial codes.
    logic [NUM_CONV-1:0][RES_W-1:0] target = '0;      // Input codes the comparators see.
    logic [31:0]                    seed = 32'h5a2f;
    logic [31:0]                    r;
    logic [RES_W-1:0]               exp_q[$];
    logic [1:0] exp_pos [4] = '{SRC_PAIR0_POS, SRC_PAIR1_NEG, SRC_PAIR1_POS, SRC_PAIR1_POS};
    logic [1:0] exp_neg [4] = '{SRC_PAIR0_NEG, SRC_PAIR0_NEG, SRC_PAIR0_NEG, SRC_PAIR1_NEG};
    int                             errors = 0, check_count = 0, rp_cnt = 0;

    always #50 clk_i = ~clk_i;

    // Counts read pulses seen by the device.
    always @(posedge clk_i) if (read_pulse_o === 1'b1) rp_cnt++;

    // Bench comparator: keep the trial bit while the trial code is not above the target.
    always @(posedge clk_i) begin
        #1;
        for (int k = 0; k < NUM_CONV; k++) cmp_i[k] = (trial_o[k] <= target[k]);
    end

    host_model u_host (.slow_i(slow), .req_i(req), .conv_clk_o(conv_clk),
                       .start_o(start), .active_o(host_active));

    dual_sar_conversion_sequencer DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .conv_clk_i(conv_clk),
        .conv_start_strobe_i(start), .read_strobe_i(start),
        .chan_sel_hi_i(chan_sel_hi_i), .chan_sel_lo_i(chan_sel_lo_i), .cmp_i(cmp_i),
        .busy_o(busy_o), .sample_close_o(sample_close_o), .precharge_o(precharge_o),
        .pos_src_o(pos_src_o), .neg_src_o(neg_src_o), .trial_o(trial_o), .result_o(result_o),
        .result_valid_o(result_valid_o), .read_pulse_o(read_pulse_o));

    // ========================================
    // Tasks
    // ========================================
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Bounded wait for the host frame level; running out counts as a mismatch.
    task automatic wait_host(input logic lvl);
        int i;
        for (i = 0; i < 400 && host_active !== lvl; i++) @(posedge clk_i);
        if (i == 400) begin
            errors++;
            finish_test();
        end
        #1;
    endtask : wait_host

    // ========================================
    // Main sequence
    // ========================================
    initial begin
        repeat (4) @(posedge clk_i);
        #1;
        chk(RES_W'({busy_o, sample_close_o, precharge_o, result_valid_o, pos_src_o,
                    neg_src_o}), 12'h041);
        sys_rst_i = 1'b0;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i);
            #1 {chan_sel_hi_i, chan_sel_lo_i} = 2'(c);
            repeat (2) @(posedge clk_i);
            #1 chk(RES_W'({pos_src_o, neg_src_o}), RES_W'({exp_pos[c], exp_neg[c]}));
        end
        for (int n = 0; n < 8; n++) begin
            @(posedge clk_i);
            #1 r = rnd();
            target = {r[31:20], r[19:8]};
            {chan_sel_hi_i, chan_sel_lo_i} = r[3:2];
            slow = r[4];
            req = 1'b1;
            exp_q.push_back(r[19:8]);
            exp_q.push_back(r[31:20]);
            wait_host(1'b1);
            req = 1'b0;
            repeat (10) @(posedge clk_i);
            #1 chk(RES_W'({busy_o, sample_close_o, result_valid_o}), 12'h004);
            wait_host(1'b0);
            repeat (2) @(posedge clk_i);
            #1 chk(result_o[0], exp_q.pop_front());
            chk(result_o[1], exp_q.pop_front());
            chk(trial_o[0], r[19:8]);
            chk(trial_o[1], r[31:20]);
            chk(RES_W'({busy_o, sample_close_o, result_valid_o}), 12'h003);
            chk(RES_W'(rp_cnt), RES_W'(n + 1));
            chk(RES_W'({pos_src_o, neg_src_o}), RES_W'({exp_pos[r[3:2]], exp_neg[r[3:2]]}));
        end
        finish_test();
    end
endmodule : testbench

bind dual_sar_conversion_sequencer seq_chk u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .conv_clk_i(conv_clk_i),
    .conv_start_strobe_i(conv_start_strobe_i), .chan_sel_hi_i(chan_sel_hi_i),
    .chan_sel_lo_i(chan_sel_lo_i), .busy_o(busy_o), .sample_close_o(sample_close_o),
    .precharge_o(precharge_o), .pos_src_o(pos_src_o), .neg_src_o(neg_src_o),
    .result_o(result_o), .result_valid_o(result_valid_o), .read_pulse_o(read_pulse_o));
